// file: rtl/difs_pkg.sv
// Purpose: constants and types for the digital input function selector
// Assumes: one 16-bit selector for input zero, reached by parameter address
// Notes: codes are those that software writes into the selector
package difs_pkg;
  localparam int CODE_W = 16;
  localparam logic [15:0] SEL_ADDR = 16'h0702;
  localparam logic [15:0] FN_NONE = 16'h0001;
  localparam logic [15:0] FN_FAULT_RESET = 16'h0002;
  localparam logic [15:0] FN_ENABLE = 16'h0003;
  localparam logic [15:0] FN_HALT = 16'h0004;
  localparam logic [15:0] FN_CURRENT_LIM = 16'h0006;
  localparam logic [15:0] FN_ZERO_CLAMP = 16'h0007;
  localparam logic [15:0] FN_VELOCITY_LIM = 16'h0008;
  localparam logic [15:0] FN_JOG_POS = 16'h0009;
  localparam logic [15:0] FN_JOG_NEG = 16'h000a;
  localparam logic [15:0] FN_JOG_FAST = 16'h000b;
  localparam logic [15:0] FN_GEAR_RATIO = 16'h000c;
  localparam logic [15:0] FN_GEAR_OFF1 = 16'h0013;
  localparam logic [15:0] FN_GEAR_OFF2 = 16'h0014;
  localparam logic [15:0] FN_REF_SWITCH = 16'h0015;
  localparam logic [15:0] FN_POS_LIMIT = 16'h0016;
  localparam logic [15:0] FN_NEG_LIMIT = 16'h0017;
  localparam logic [15:0] FN_PAR_SET = 16'h0018;
  localparam logic [15:0] FN_INV_ANALOG_ONE = 16'h0019;
  localparam logic [15:0] FN_INV_ANALOG_TWO = 16'h001a;
  localparam logic [15:0] FN_MODE_SWITCH = 16'h001b;
  localparam logic [15:0] FN_INTEGRAL_OFF = 16'h001c;
  // factory default of input zero is the same in every mode
  localparam logic [15:0] SEL_DEFAULT = FN_ENABLE;

  typedef enum logic [1:0] {
    MODE_JOG = 2'b00,
    MODE_GEAR = 2'b01,
    MODE_TORQUE = 2'b10,
    MODE_VELOCITY = 2'b11
  } difs_mode_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [15:0] addr;
    logic [15:0] wdata;
  } difs_par_req_type;

  typedef struct packed {
    logic done;
    logic reject;
    logic [15:0] rdata;
  } difs_par_rsp_type;

  typedef struct packed {
    logic faultReset;
    logic enable;
    logic halt;
    logic currentLimit;
    logic zeroClamp;
    logic velocityLimit;
    logic jogPositive;
    logic jogNegative;
    logic jogFast;
    logic gearRatio;
    logic gearOffsetOne;
    logic gearOffsetTwo;
    logic referenceSwitch;
    logic positiveTravelLimit;
    logic negativeTravelLimit;
    logic parameterSet;
    logic invertAnalogInputOne;
    logic invertAnalogInputTwo;
    logic modeSwitch;
    logic integralOff;
  } difs_func_type;
endpackage

// file: rtl/difs_selector.sv
// Purpose: assigns one function to digital input zero from a stored code
// Assumes: powerStageOn, opMode and powerUp come from logic on clk
// Notes: the pin is synchronised; function outputs are registered
`timescale 1ns/1ps
module difs_selector
#(
  parameter int CODE_WIDTH = difs_pkg::CODE_W
)
(
  input wire logic clk, // 125 MHz
  input wire logic rst, // sync, active high
  input wire logic digitalInputZero, // pin, asynchronous
  input wire logic powerStageOn, // power stage enabled
  input wire logic powerUp, // one pulse per switch-on
  input wire difs_pkg::difs_mode_type opMode, // active operating mode
  input wire difs_pkg::difs_par_req_type parReq, // parameter request
  output difs_pkg::difs_par_rsp_type parRsp, // parameter answer
  output logic [15:0] activeCode, // code in force
  output difs_pkg::difs_func_type funcOut // function requests
);
  import difs_pkg::*;

  if (CODE_WIDTH != 16)
  begin : g_chk
    $error("difs_selector: code width must be 16");
  end

  logic pinMeta;
  logic pinSync;
  logic [15:0] storedCode;
  logic [15:0] next_storedCode;
  logic [15:0] next_activeCode;
  difs_mode_type lastMode;
  logic modeChanged;
  logic hitSel;
  logic codeValid;
  logic writeOk;
  logic [15:0] wCode;
  logic modeJog;
  logic modeGear;
  logic modeAnalog;
  logic modeClamp;
  difs_func_type next_funcOut;
  difs_par_rsp_type next_parRsp;

  assign wCode = parReq.wdata;
  assign hitSel = (parReq.addr == SEL_ADDR);
  assign modeChanged = (opMode != lastMode);
  assign modeJog = (opMode == MODE_JOG);
  assign modeGear = (opMode == MODE_GEAR);
  assign modeAnalog = (opMode == MODE_TORQUE) || (opMode == MODE_VELOCITY);
  assign modeClamp = (opMode == MODE_GEAR) || (opMode == MODE_VELOCITY);

  // gaps at 5 and 13 to 18 are not functions
  assign codeValid = ((wCode >= FN_NONE) && (wCode <= FN_HALT))
    || ((wCode >= FN_CURRENT_LIM) && (wCode <= FN_GEAR_RATIO))
    || ((wCode >= FN_GEAR_OFF1) && (wCode <= FN_INTEGRAL_OFF));

  // a refused write leaves the stored code untouched
  assign writeOk = parReq.write && hitSel && !powerStageOn && codeValid;

  // mode change resets to factory default, which outranks a same-cycle write
  assign next_storedCode = modeChanged ? SEL_DEFAULT
    : writeOk ? wCode
    : storedCode;

  // the pending code only reaches the live assignment on switch-on
  assign next_activeCode = modeChanged ? SEL_DEFAULT
    : powerUp ? storedCode
    : activeCode;

  always_comb
  begin
    next_parRsp = '0;
    next_parRsp.done = parReq.write || parReq.read;
    if (parReq.write)
    begin
      next_parRsp.reject = !writeOk;
    end
    else if (parReq.read && hitSel)
    begin
      next_parRsp.rdata = storedCode;
    end
    else if (parReq.read)
    begin
      next_parRsp.reject = 1'b1;
    end
  end

  always_comb
  begin
    next_funcOut = '0;
    case (activeCode)
      FN_FAULT_RESET: next_funcOut.faultReset = pinSync;
      FN_ENABLE: next_funcOut.enable = pinSync;
      FN_HALT: next_funcOut.halt = pinSync;
      FN_CURRENT_LIM: next_funcOut.currentLimit = pinSync;
      FN_ZERO_CLAMP: next_funcOut.zeroClamp = pinSync && modeClamp;
      FN_VELOCITY_LIM: next_funcOut.velocityLimit = pinSync;
      FN_JOG_POS: next_funcOut.jogPositive = pinSync && modeJog;
      FN_JOG_NEG: next_funcOut.jogNegative = pinSync && modeJog;
      FN_JOG_FAST: next_funcOut.jogFast = pinSync && modeJog;
      FN_GEAR_RATIO: next_funcOut.gearRatio = pinSync && modeGear;
      FN_GEAR_OFF1: next_funcOut.gearOffsetOne = pinSync && modeGear;
      FN_GEAR_OFF2: next_funcOut.gearOffsetTwo = pinSync && modeGear;
      FN_REF_SWITCH: next_funcOut.referenceSwitch = pinSync;
      FN_POS_LIMIT: next_funcOut.positiveTravelLimit = pinSync;
      FN_NEG_LIMIT: next_funcOut.negativeTravelLimit = pinSync;
      FN_PAR_SET: next_funcOut.parameterSet = pinSync;
      FN_INV_ANALOG_ONE: next_funcOut.invertAnalogInputOne = pinSync && modeAnalog;
      FN_INV_ANALOG_TWO: next_funcOut.invertAnalogInputTwo = pinSync && modeAnalog;
      FN_MODE_SWITCH: next_funcOut.modeSwitch = pinSync;
      FN_INTEGRAL_OFF: next_funcOut.integralOff = pinSync;
      default: next_funcOut = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    pinMeta <= digitalInputZero;
    pinSync <= pinMeta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      storedCode <= SEL_DEFAULT;
      activeCode <= SEL_DEFAULT;
      lastMode <= MODE_JOG;
      parRsp <= '0;
      funcOut <= '0;
    end
    else
    begin
      storedCode <= next_storedCode;
      activeCode <= next_activeCode;
      lastMode <= opMode;
      parRsp <= next_parRsp;
      funcOut <= next_funcOut;
    end
  end

  a_write_blocked_on: assert property (@(posedge clk) disable iff (rst)
    parReq.write && powerStageOn && !modeChanged |=> storedCode == $past(storedCode))
    else $error("write changed selector while power stage on");

  a_write_reject_flag: assert property (@(posedge clk) disable iff (rst)
    parReq.write && powerStageOn |=> parRsp.done && parRsp.reject)
    else $error("write under power not answered as refused");

  a_bad_code_kept: assert property (@(posedge clk) disable iff (rst)
    parReq.write && hitSel && (wCode == 16'h0005 || wCode == 16'h0000) && !modeChanged
    |=> storedCode == $past(storedCode) && parRsp.reject)
    else $error("unlisted code accepted");

  a_good_write_stored: assert property (@(posedge clk) disable iff (rst)
    parReq.write && hitSel && !powerStageOn && wCode == FN_HALT && !modeChanged
    |=> storedCode == FN_HALT && !parRsp.reject)
    else $error("valid write not stored");

  a_write_not_live: assert property (@(posedge clk) disable iff (rst)
    !powerUp && !modeChanged |=> activeCode == $past(activeCode))
    else $error("active code changed without power-up");

  a_power_up_loads: assert property (@(posedge clk) disable iff (rst)
    powerUp && !modeChanged |=> activeCode == $past(storedCode))
    else $error("power-up did not load stored code");

  a_mode_default: assert property (@(posedge clk) disable iff (rst)
    modeChanged |=> activeCode == SEL_DEFAULT && storedCode == SEL_DEFAULT)
    else $error("mode change did not restore default");

  a_jog_gated: assert property (@(posedge clk) disable iff (rst)
    !modeJog |=> !funcOut.jogPositive && !funcOut.jogNegative && !funcOut.jogFast)
    else $error("jog function outside jog mode");

  a_gear_gated: assert property (@(posedge clk) disable iff (rst)
    !modeGear |=> !funcOut.gearRatio && !funcOut.gearOffsetOne && !funcOut.gearOffsetTwo)
    else $error("gear function outside gear mode");

  a_analog_gated: assert property (@(posedge clk) disable iff (rst)
    !modeAnalog |=> !funcOut.invertAnalogInputOne && !funcOut.invertAnalogInputTwo)
    else $error("analog inversion in wrong mode");

  a_enable_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_ENABLE && $stable(activeCode) |=> funcOut.enable == $past(pinSync))
    else $error("enable does not follow input");

  a_halt_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_HALT |=> funcOut.halt == $past(pinSync) && !funcOut.enable)
    else $error("halt does not follow input");

  a_limit_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_POS_LIMIT |=> funcOut.positiveTravelLimit == $past(pinSync))
    else $error("positive limit does not follow input");

  a_current_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_CURRENT_LIM |=> funcOut.currentLimit == $past(pinSync))
    else $error("current limit does not follow input");

  a_integral_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_INTEGRAL_OFF |=> funcOut.integralOff == $past(pinSync))
    else $error("integral off does not follow input");

  a_jog_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_JOG_POS && modeJog |=> funcOut.jogPositive == $past(pinSync))
    else $error("jog positive does not follow input");

  a_gear_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_GEAR_OFF2 && modeGear |=> funcOut.gearOffsetTwo == $past(pinSync))
    else $error("gear offset two does not follow input");

  a_invert_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_INV_ANALOG_TWO && modeAnalog |=> funcOut.invertAnalogInputTwo == $past(pinSync))
    else $error("inversion two does not follow input");

  a_invert_one: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_INV_ANALOG_ONE && modeAnalog |=> funcOut.invertAnalogInputOne == $past(pinSync))
    else $error("inversion one does not follow input");

  a_fault_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_FAULT_RESET |=> funcOut.faultReset == $past(pinSync))
    else $error("fault reset does not follow input");

  a_none_silent: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_NONE |=> funcOut == '0)
    else $error("input without function raised a request");

  // one code can only ever select one function
  a_single_function: assert property (@(posedge clk) disable iff (rst)
    $onehot0(funcOut))
    else $error("more than one function active");

  a_velocity_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_VELOCITY_LIM |=> funcOut.velocityLimit == $past(pinSync))
    else $error("velocity limit does not follow input");

  a_clamp_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_ZERO_CLAMP && modeClamp |=> funcOut.zeroClamp == $past(pinSync))
    else $error("zero clamp does not follow input");

  a_clamp_gated: assert property (@(posedge clk) disable iff (rst)
    !modeClamp |=> !funcOut.zeroClamp)
    else $error("zero clamp in wrong mode");

  a_jogneg_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_JOG_NEG && modeJog |=> funcOut.jogNegative == $past(pinSync))
    else $error("jog negative does not follow input");

  a_jogfast_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_JOG_FAST && modeJog |=> funcOut.jogFast == $past(pinSync))
    else $error("jog speed toggle does not follow input");

  a_ratio_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_GEAR_RATIO && modeGear |=> funcOut.gearRatio == $past(pinSync))
    else $error("gear ratio does not follow input");

  a_offset_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_GEAR_OFF1 && modeGear |=> funcOut.gearOffsetOne == $past(pinSync))
    else $error("gear offset one does not follow input");

  a_ref_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_REF_SWITCH |=> funcOut.referenceSwitch == $past(pinSync))
    else $error("reference switch does not follow input");

  a_neglimit_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_NEG_LIMIT |=> funcOut.negativeTravelLimit == $past(pinSync))
    else $error("negative limit does not follow input");

  a_parset_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_PAR_SET |=> funcOut.parameterSet == $past(pinSync))
    else $error("parameter set switch does not follow input");

  a_modesw_follows: assert property (@(posedge clk) disable iff (rst)
    activeCode == FN_MODE_SWITCH |=> funcOut.modeSwitch == $past(pinSync))
    else $error("mode switch does not follow input");

  // every request is answered, so a refusal is always visible to the writer
  a_answer_done: assert property (@(posedge clk) disable iff (rst)
    parReq.write || parReq.read |=> parRsp.done)
    else $error("request not answered");

  a_no_idle_answer: assert property (@(posedge clk) disable iff (rst)
    !parReq.write && !parReq.read |=> !parRsp.done)
    else $error("answer without request");

  a_read_pending: assert property (@(posedge clk) disable iff (rst)
    parReq.read && !parReq.write && hitSel |=> parRsp.rdata == $past(storedCode) && !parRsp.reject)
    else $error("read does not return the stored code");

  a_high_code_kept: assert property (@(posedge clk) disable iff (rst)
    parReq.write && hitSel && wCode > FN_INTEGRAL_OFF && !modeChanged
    |=> storedCode == $past(storedCode) && parRsp.reject)
    else $error("code above range accepted");

endmodule

// file: sim/difs_switch_model.sv
// Purpose: behavioural switch wired to digital input zero
// Assumes: contact driven from the drive supply, no pull on the line
// Notes: the level settles off the clock grid, like a real contact
`timescale 1ns/1ps
module difs_switch_model
#(
  parameter real SETTLE = 2.7
)
(
  input wire logic press, // high = contact closed
  output logic level // pin level seen by the drive
);
  // unaligned settle time makes the synchroniser earn its keep
  initial level = 1'b0;
  always @(press) level <= #(SETTLE) press;
endmodule

// file: sim/test_digital_input_function_selector.sv
// Purpose: self-checking bench for the input zero function selector
// Assumes: 125 MHz clk, switch model on the pin
// Notes: parameter answers are checked from a queue of expected notes
`timescale 1ns/1ps
module test_digital_input_function_selector;
  import difs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic powerStageOn = 1'b0;
  logic powerUp = 1'b0;
  logic press = 1'b0;
  logic digitalInputZero;
  difs_mode_type opMode = MODE_JOG;
  difs_par_req_type parReq = '0;
  difs_par_rsp_type parRsp;
  logic [15:0] activeCode;
  difs_func_type funcOut;
  logic [18:0] expQ[$];
  logic [18:0] note;
  int miscompares = 0;
  int totalChecks = 0;
  // codes in the bit order of funcOut, last the code without function
  logic [15:0] codeTab[21] = '{16'h2, 16'h3, 16'h4, 16'h6, 16'h7, 16'h8, 16'h9, 16'ha, 16'hb, 16'hc, 16'h13,
    16'h14, 16'h15, 16'h16, 16'h17, 16'h18, 16'h19, 16'h1a, 16'h1b, 16'h1c, 16'h1};
  logic [15:0] badTab[9] = '{16'h0, 16'h5, 16'hd, 16'he, 16'hf, 16'h10, 16'h11, 16'h12, 16'h1d};

  always #4 clk = ~clk;
  difs_switch_model difs_switch_model_i (.press(press), .level(digitalInputZero));
  difs_selector difs_selector_i (.clk(clk), .rst(rst), .digitalInputZero(digitalInputZero),
    .powerStageOn(powerStageOn), .powerUp(powerUp), .opMode(opMode), .parReq(parReq), .parRsp(parRsp),
    .activeCode(activeCode), .funcOut(funcOut));

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] expv, logic [31:0] gotv);
    totalChecks++;
    if (gotv !== expv)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, expv, gotv);
    end
  endtask

  // note layout: is-read, done, reject, rdata; writes are judged on reject only
  always @(posedge clk)
  begin
    if (parRsp.done === 1'b1)
    begin
      note = (expQ.size() != 0) ? expQ.pop_front() : 19'h7ffff;
      if (note[18])
        check("read answer", note[17:0], parRsp);
      else
        check("write reject", note[16], parRsp.reject);
    end
  end

  task automatic req(logic wr, logic [15:0] addr, logic [15:0] data, logic rej, logic [15:0] rd);
    @(negedge clk);
    parReq = '{write: wr, read: ~wr, addr: addr, wdata: data};
    expQ.push_back({~wr, 1'b1, rej, rd});
    @(negedge clk);
    parReq = '0;
    for (int n = 0; n < 10 && expQ.size() != 0; n++)
      @(negedge clk);
    if (expQ.size() != 0)
    begin
      miscompares++;
      giveVerdict();
    end
  endtask

  // two writes in a row, the second always a change, so the mode default is always reloaded
  task automatic set_mode(int m);
    @(negedge clk);
    opMode = difs_mode_type'(m ^ 1);
    @(negedge clk);
    opMode = difs_mode_type'(m);
    repeat (2) @(negedge clk);
  endtask

  task automatic pulse_power();
    @(negedge clk);
    powerUp = 1'b1;
    @(negedge clk);
    powerUp = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  function automatic logic [19:0] exp_func(int i, int m);
    logic ok;
    ok = (i >= 6 && i <= 8) ? m == 0 : (i >= 9 && i <= 11) ? m == 1 : (i == 16 || i == 17) ? m >= 2 :
      (i == 4) ? (m == 1 || m == 3) : 1'b1;
    return (ok && i < 20) ? (20'h80000 >> i) : 20'h0;
  endfunction

  initial
  begin
    #160000;
    miscompares++;
    giveVerdict();
  end

  initial
  begin
    void'($urandom(32'h35477a96));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("activeCode", SEL_DEFAULT, activeCode);
    req(1'b0, SEL_ADDR, 16'h0, 1'b0, SEL_DEFAULT);
    for (int m = 0; m < 4; m++)
    begin
      for (int i = 0; i < 21; i++)
      begin
        set_mode(m);
        req(1'b1, SEL_ADDR, codeTab[i], 1'b0, 16'h0);
        check("activeCode", SEL_DEFAULT, activeCode);
        req(1'b0, SEL_ADDR, 16'h0, 1'b0, codeTab[i]);
        pulse_power();
        check("activeCode", codeTab[i], activeCode);
        press = 1'b1;
        repeat (6) @(negedge clk);
        check("funcOut", exp_func(i, m), funcOut);
        press = 1'b0;
        repeat (6) @(negedge clk);
        check("funcOut idle", 32'h0, funcOut);
      end
    end
    set_mode(0);
    powerStageOn = 1'b1;
    req(1'b1, SEL_ADDR, codeTab[$urandom_range(19, 2)], 1'b1, 16'h0);
    powerStageOn = 1'b0;
    for (int k = 0; k < 10; k++)
      req(1'b1, SEL_ADDR, (k < 9) ? badTab[k] : 16'($urandom_range(65535, 29)), 1'b1, 16'h0);
    req(1'b1, SEL_ADDR + 16'h1, 16'h4, 1'b1, 16'h0);
    req(1'b0, SEL_ADDR + 16'h1, 16'h0, 1'b1, 16'h0);
    req(1'b0, SEL_ADDR, 16'h0, 1'b0, SEL_DEFAULT);
    req(1'b1, SEL_ADDR, 16'h4, 1'b0, 16'h0);
    pulse_power();
    check("activeCode", 16'h4, activeCode);
    set_mode(1);
    check("activeCode", SEL_DEFAULT, activeCode);
    req(1'b0, SEL_ADDR, 16'h0, 1'b0, SEL_DEFAULT);
    giveVerdict();
  end
endmodule
